/* pcm_tdm_single_clock_port.sv */
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Every slot is shifted out and in most significant bit first.
// - Transmit bits launch on rising bit clock edges, receive bits sampled on falling.
// - Control bit picks rising or falling bit clock edge for frame sync sampling.
// - Each channel has separate transmit and receive offsets of zero to seven bits.
// - Linear coding uses two back-to-back eight-bit slots instead of one.
// - Each slot-active output, A or B, is low exactly while a channel selected onto it drives transmit data.
// - Transmit data output is released when the assigned slot ends.
// - Each offset unit shifts that direction by exactly one bit clock.
module pcm_tdm_single_clock_port
    import pcm_tdm_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_pcm_bit_clk,
    input  wire logic        i_frame_sync,
    input  wire logic        i_pcm_rx_data,
    output logic             o_pcm_tx_data,
    output logic             o_pcm_tx_data_oe,
    output logic             o_tx_slot_active_a_n,
    output logic             o_tx_slot_active_b_n
);

    // Pin synchronisers
    logic [1:0] bclk_sync_ff, nxt_bclk_sync;
    logic [1:0] fs_sync_ff, nxt_fs_sync;
    logic [1:0] rxd_sync_ff, nxt_rxd_sync;
    logic       bclk_prev_ff, nxt_bclk_prev;

    // Frame timing
    logic        fs_prev_ff, nxt_fs_prev;
    logic        frame_armed_ff, nxt_frame_armed;
    logic [11:0] bit_pos_ff, nxt_bit_pos;
    logic [15:0] frame_cnt_ff, nxt_frame_cnt;
    logic        locked_ff, nxt_locked;

    // Registers
    logic [1:0]          ctrl_ff, nxt_ctrl;
    logic [31:0]         cfg_ff [NUM_CH];
    logic [31:0]         nxt_cfg [NUM_CH];
    logic [15:0]         tx_word_ff [NUM_CH];
    logic [15:0]         nxt_tx_word [NUM_CH];
    logic [NUM_CH-1:0]   rx_ready_ff, nxt_rx_ready;
    logic                ack_ff, nxt_ack;
    logic [31:0]         rdata_ff, nxt_rdata;

    // Pin outputs
    logic tx_data_ff, nxt_tx_data;
    logic tx_oe_ff, nxt_tx_oe;
    logic act_a_n_ff, nxt_act_a_n;
    logic act_b_n_ff, nxt_act_b_n;

    logic              bit_rise;
    logic              bit_fall;
    logic              fs_edge;
    logic              frame_hit;
    logic              wb_req;
    logic [31:0]       wmask;
    logic [NUM_CH-1:0] lane_active;
    logic [NUM_CH-1:0] lane_bit;
    logic [NUM_CH-1:0] lane_done;
    logic [15:0]       lane_rx_word [NUM_CH];

    // Link side: sample pins, find bit clock edges, track frame position
    always_comb begin
        nxt_bclk_sync = {bclk_sync_ff[0], i_pcm_bit_clk};
        nxt_fs_sync   = {fs_sync_ff[0], i_frame_sync};
        nxt_rxd_sync  = {rxd_sync_ff[0], i_pcm_rx_data};
        nxt_bclk_prev = bclk_sync_ff[1];
        bit_rise      = bclk_sync_ff[1] && !bclk_prev_ff;
        bit_fall      = !bclk_sync_ff[1] && bclk_prev_ff;
        // Sync and data share synchroniser depth, so their phase is kept
        fs_edge       = ctrl_ff[CTRL_FS_RISE_BIT] ? bit_rise : bit_fall;
        frame_hit     = ctrl_ff[CTRL_ENABLE_BIT] && fs_edge
                        && fs_sync_ff[1] && !fs_prev_ff;

        nxt_fs_prev     = fs_edge ? fs_sync_ff[1] : fs_prev_ff;
        nxt_frame_armed = frame_armed_ff;
        nxt_bit_pos     = bit_pos_ff;
        nxt_frame_cnt   = frame_cnt_ff;
        nxt_locked      = locked_ff;

        if (frame_hit) begin
            nxt_frame_armed = 1'b1;
            nxt_frame_cnt   = frame_cnt_ff + 16'd1;
            nxt_locked      = 1'b1;
        end
        if (!ctrl_ff[CTRL_ENABLE_BIT]) begin
            nxt_frame_armed = 1'b0;
            nxt_bit_pos     = BIT_POS_IDLE;
            nxt_locked      = 1'b0;
        end else if (bit_rise) begin
            if (frame_armed_ff) begin
                nxt_frame_armed = frame_hit;
                nxt_bit_pos     = 12'd0;
            end else if (bit_pos_ff != BIT_POS_IDLE) begin
                // Saturates so a missing sync never wraps into slot 0
                nxt_bit_pos = bit_pos_ff + 12'd1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bclk_sync_ff   <= 2'b00;
            fs_sync_ff     <= 2'b00;
            rxd_sync_ff    <= 2'b00;
            bclk_prev_ff   <= 1'b0;
            fs_prev_ff     <= 1'b0;
            frame_armed_ff <= 1'b0;
            bit_pos_ff     <= BIT_POS_IDLE;
            frame_cnt_ff   <= 16'h0000;
            locked_ff      <= 1'b0;
        end else begin
            bclk_sync_ff   <= nxt_bclk_sync;
            fs_sync_ff     <= nxt_fs_sync;
            rxd_sync_ff    <= nxt_rxd_sync;
            bclk_prev_ff   <= nxt_bclk_prev;
            fs_prev_ff     <= nxt_fs_prev;
            frame_armed_ff <= nxt_frame_armed;
            bit_pos_ff     <= nxt_bit_pos;
            frame_cnt_ff   <= nxt_frame_cnt;
            locked_ff      <= nxt_locked;
        end
    end

    // Per-channel slot engines
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_lane
            pcm_slot_lane u_lane (
                .i_sys_clk   (i_sys_clk),
                .i_reset     (i_reset),
                .i_bit_rise  (bit_rise && ctrl_ff[CTRL_ENABLE_BIT]),
                .i_bit_fall  (bit_fall),
                .i_bit_pos   (nxt_bit_pos),
                .i_rx_bit    (rxd_sync_ff[1]),
                .i_tx_slot   (cfg_ff[g][CFG_TX_SLOT_LSB +: 8]),
                .i_rx_slot   (cfg_ff[g][CFG_RX_SLOT_LSB +: 8]),
                .i_tx_offset (cfg_ff[g][CFG_TX_OFS_LSB +: 3]),
                .i_rx_offset (cfg_ff[g][CFG_RX_OFS_LSB +: 3]),
                .i_linear    (cfg_ff[g][CFG_LINEAR_BIT]),
                .i_tx_enable (cfg_ff[g][CFG_TX_EN_BIT]),
                .i_rx_enable (cfg_ff[g][CFG_RX_EN_BIT]),
                .i_tx_word   (tx_word_ff[g]),
                .o_tx_active (lane_active[g]),
                .o_tx_bit    (lane_bit[g]),
                .o_rx_word   (lane_rx_word[g]),
                .o_rx_done   (lane_done[g])
            );
        end
    endgenerate

    // Shared bus driver and slot-active strobes
    always_comb begin
        nxt_tx_data = |(lane_bit & lane_active);
        nxt_tx_oe   = |lane_active;
        nxt_act_a_n = 1'b1;
        nxt_act_b_n = 1'b1;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (lane_active[ch] && cfg_ff[ch][CFG_ACT_SEL_BIT]) begin
                nxt_act_b_n = 1'b0;
            end else if (lane_active[ch]) begin
                nxt_act_a_n = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_data_ff <= 1'b0;
            tx_oe_ff   <= 1'b0;
            act_a_n_ff <= 1'b1;
            act_b_n_ff <= 1'b1;
        end else begin
            tx_data_ff <= nxt_tx_data;
            tx_oe_ff   <= nxt_tx_oe;
            act_a_n_ff <= nxt_act_a_n;
            act_b_n_ff <= nxt_act_b_n;
        end
    end

    // Wishbone classic slave, one wait state, unmapped reads return zero
    always_comb begin
        wb_req = i_wb_cyc && i_wb_stb && !ack_ff;
        wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
        nxt_ack   = wb_req;
        nxt_rdata = 32'h0000_0000;
        nxt_ctrl  = ctrl_ff;
        // Hardware set wins over a same-cycle software clear
        nxt_rx_ready = rx_ready_ff | lane_done;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            nxt_cfg[ch]     = cfg_ff[ch];
            nxt_tx_word[ch] = tx_word_ff[ch];
        end

        if (wb_req) begin
            if (i_wb_adr == CTRL_OFS) begin
                nxt_rdata = {30'd0, ctrl_ff};
                if (i_wb_we && i_wb_sel[0]) begin
                    nxt_ctrl = i_wb_dat[1:0];
                end
            end else if (i_wb_adr == STATUS_OFS) begin
                nxt_rdata = {27'd0, locked_ff, rx_ready_ff};
                if (i_wb_we && i_wb_sel[0]) begin
                    nxt_rx_ready = (rx_ready_ff & ~i_wb_dat[NUM_CH-1:0]) | lane_done;
                end
            end else if (i_wb_adr == FRAME_CNT_OFS) begin
                nxt_rdata = {16'd0, frame_cnt_ff};
            end else begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (i_wb_adr == CH_BASE_OFS + 8'(ch) * CH_STRIDE + CH_CFG_OFS) begin
                        nxt_rdata = cfg_ff[ch];
                        if (i_wb_we) begin
                            nxt_cfg[ch] = ((cfg_ff[ch] & ~wmask) | (i_wb_dat & wmask))
                                          & CFG_WR_MASK;
                        end
                    end else if (i_wb_adr == CH_BASE_OFS + 8'(ch) * CH_STRIDE
                                 + CH_TX_DATA_OFS) begin
                        nxt_rdata = {16'd0, tx_word_ff[ch]};
                        if (i_wb_we) begin
                            nxt_tx_word[ch] = (tx_word_ff[ch] & ~wmask[15:0])
                                              | (i_wb_dat[15:0] & wmask[15:0]);
                        end
                    end else if (i_wb_adr == CH_BASE_OFS + 8'(ch) * CH_STRIDE
                                 + CH_RX_DATA_OFS) begin
                        nxt_rdata = {16'd0, lane_rx_word[ch]};
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_ff     <= CTRL_RESET;
            rx_ready_ff <= '0;
            ack_ff      <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                cfg_ff[ch]     <= CFG_RESET;
                tx_word_ff[ch] <= TX_DATA_RESET;
            end
        end else begin
            ctrl_ff     <= nxt_ctrl;
            rx_ready_ff <= nxt_rx_ready;
            ack_ff      <= nxt_ack;
            rdata_ff    <= nxt_rdata;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                cfg_ff[ch]     <= nxt_cfg[ch];
                tx_word_ff[ch] <= nxt_tx_word[ch];
            end
        end
    end

    assign o_wb_dat             = rdata_ff;
    assign o_wb_ack             = ack_ff;
    assign o_pcm_tx_data        = tx_data_ff;
    assign o_pcm_tx_data_oe     = tx_oe_ff;
    assign o_tx_slot_active_a_n = act_a_n_ff;
    assign o_tx_slot_active_b_n = act_b_n_ff;

endmodule

/* pcm_tdm_pkg.sv */
package pcm_tdm_pkg;

    localparam int NUM_CH = 4;

    // Wishbone register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;
    localparam logic [7:0] FRAME_CNT_OFS  = 8'h08;
    localparam logic [7:0] CH_BASE_OFS    = 8'h10;
    localparam logic [7:0] CH_STRIDE      = 8'h10;
    localparam logic [7:0] CH_CFG_OFS     = 8'h00;
    localparam logic [7:0] CH_TX_DATA_OFS = 8'h04;
    localparam logic [7:0] CH_RX_DATA_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_FS_RISE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Status register fields
    localparam int STATUS_RX_READY_LSB = 0;
    localparam int STATUS_LOCKED_BIT   = 4;

    // Channel configuration fields
    localparam int CFG_TX_SLOT_LSB   = 0;
    localparam int CFG_RX_SLOT_LSB   = 8;
    localparam int CFG_TX_OFS_LSB    = 16;
    localparam int CFG_RX_OFS_LSB    = 20;
    localparam int CFG_LINEAR_BIT    = 24;
    localparam int CFG_TX_EN_BIT     = 25;
    localparam int CFG_RX_EN_BIT     = 26;
    localparam int CFG_ACT_SEL_BIT   = 27;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    localparam logic [31:0] CFG_WR_MASK   = 32'h0F77_FFFF;
    localparam logic [15:0] TX_DATA_RESET = 16'h0000;

    // Slot geometry
    localparam int          BITS_PER_SLOT = 8;
    localparam logic [4:0]  LEN_COMPANDED = 5'd8;
    localparam logic [4:0]  LEN_LINEAR    = 5'd16;
    localparam logic [11:0] BIT_POS_IDLE  = 12'hFFF;

endpackage

/* pcm_slot_lane.sv */
`timescale 1ns/1ps
module pcm_slot_lane
    import pcm_tdm_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_bit_rise,
    input  wire logic        i_bit_fall,
    input  wire logic [11:0] i_bit_pos,
    input  wire logic        i_rx_bit,
    input  wire logic [7:0]  i_tx_slot,
    input  wire logic [7:0]  i_rx_slot,
    input  wire logic [2:0]  i_tx_offset,
    input  wire logic [2:0]  i_rx_offset,
    input  wire logic        i_linear,
    input  wire logic        i_tx_enable,
    input  wire logic        i_rx_enable,
    input  wire logic [15:0] i_tx_word,
    output logic             o_tx_active,
    output logic             o_tx_bit,
    output logic [15:0]      o_rx_word,
    output logic             o_rx_done
);

    logic        tx_active_ff, nxt_tx_active;
    logic        tx_bit_ff, nxt_tx_bit;
    logic [15:0] tx_shift_ff, nxt_tx_shift;
    logic        rx_arm_ff, nxt_rx_arm;
    logic        rx_last_ff, nxt_rx_last;
    logic [15:0] rx_acc_ff, nxt_rx_acc;
    logic [15:0] rx_word_ff, nxt_rx_word;
    logic        rx_done_ff, nxt_rx_done;

    logic [11:0] tx_start;
    logic [11:0] rx_start;
    logic [11:0] tx_idx;
    logic [11:0] rx_idx;
    logic [11:0] slot_len;
    logic        tx_in;
    logic        rx_in;
    logic [15:0] tx_load;

    always_comb begin
        // Slot n starts at bit 8n plus the direction's offset
        tx_start = {1'b0, i_tx_slot, 3'b000} + {9'd0, i_tx_offset};
        rx_start = {1'b0, i_rx_slot, 3'b000} + {9'd0, i_rx_offset};
        slot_len = {7'd0, i_linear ? LEN_LINEAR : LEN_COMPANDED};
        tx_idx   = i_bit_pos - tx_start;
        rx_idx   = i_bit_pos - rx_start;
        tx_in    = i_tx_enable && (i_bit_pos >= tx_start) && (tx_idx < slot_len);
        rx_in    = i_rx_enable && (i_bit_pos >= rx_start) && (rx_idx < slot_len);
        // Companded sample sits in the low byte, sent MSB first
        tx_load  = i_linear ? i_tx_word : {i_tx_word[7:0], 8'h00};

        nxt_tx_active = tx_active_ff;
        nxt_tx_bit    = tx_bit_ff;
        nxt_tx_shift  = tx_shift_ff;
        nxt_rx_arm    = rx_arm_ff;
        nxt_rx_last   = rx_last_ff;
        nxt_rx_acc    = rx_acc_ff;
        nxt_rx_word   = rx_word_ff;
        nxt_rx_done   = 1'b0;

        if (i_bit_rise) begin
            nxt_tx_active = tx_in;
            if (!tx_in) begin
                nxt_tx_bit = 1'b0;
            end else if (tx_idx == 12'd0) begin
                // Snapshot at slot start so a mid-slot write cannot tear the sample
                nxt_tx_bit   = tx_load[15];
                nxt_tx_shift = {tx_load[14:0], 1'b0};
            end else begin
                nxt_tx_bit   = tx_shift_ff[15];
                nxt_tx_shift = {tx_shift_ff[14:0], 1'b0};
            end
            nxt_rx_arm  = rx_in;
            nxt_rx_last = (rx_idx == slot_len - 12'd1);
        end

        if (i_bit_fall && rx_arm_ff) begin
            nxt_rx_arm = 1'b0;
            nxt_rx_acc = {rx_acc_ff[14:0], i_rx_bit};
            if (rx_last_ff) begin
                nxt_rx_done = 1'b1;
                nxt_rx_word = i_linear ? {rx_acc_ff[14:0], i_rx_bit}
                                       : {8'h00, rx_acc_ff[6:0], i_rx_bit};
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_active_ff <= 1'b0;
            tx_bit_ff    <= 1'b0;
            tx_shift_ff  <= 16'h0000;
            rx_arm_ff    <= 1'b0;
            rx_last_ff   <= 1'b0;
            rx_acc_ff    <= 16'h0000;
            rx_word_ff   <= 16'h0000;
            rx_done_ff   <= 1'b0;
        end else begin
            tx_active_ff <= nxt_tx_active;
            tx_bit_ff    <= nxt_tx_bit;
            tx_shift_ff  <= nxt_tx_shift;
            rx_arm_ff    <= nxt_rx_arm;
            rx_last_ff   <= nxt_rx_last;
            rx_acc_ff    <= nxt_rx_acc;
            rx_word_ff   <= nxt_rx_word;
            rx_done_ff   <= nxt_rx_done;
        end
    end

    assign o_tx_active = tx_active_ff;
    assign o_tx_bit    = tx_bit_ff;
    assign o_rx_word   = rx_word_ff;
    assign o_rx_done   = rx_done_ff;

endmodule

/* pcm_tdm_port_checker.sv */
`timescale 1ns/1ps
module pcm_tdm_port_checker
    import pcm_tdm_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [31:0] o_wb_dat,
    input  wire logic        o_wb_ack,
    input  wire logic        i_pcm_bit_clk,
    input  wire logic        i_frame_sync,
    input  wire logic        i_pcm_rx_data,
    input  wire logic        o_pcm_tx_data,
    input  wire logic        o_pcm_tx_data_oe,
    input  wire logic        o_tx_slot_active_a_n,
    input  wire logic        o_tx_slot_active_b_n
);
    logic       bclk_ff;
    logic       bclk_rise;
    logic [5:0] since_ff;
    logic [5:0] nxt_since;
    logic [4:0] rises_ff;
    logic [4:0] nxt_rises;

    // Raw pin seen two samples early, so design launches trail this count
    always_comb begin
        bclk_rise = i_pcm_bit_clk && !bclk_ff;
        nxt_since = bclk_rise ? 6'h00 : (since_ff == 6'h3F ? since_ff : since_ff + 6'h01);
        nxt_rises = o_pcm_tx_data_oe ? rises_ff + {4'h0, bclk_rise} : 5'h00;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bclk_ff  <= 1'b0;
            since_ff <= 6'h00;
            rises_ff <= 5'h00;
        end else begin
            bclk_ff  <= i_pcm_bit_clk;
            since_ff <= nxt_since;
            rises_ff <= nxt_rises;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack stood longer than one cycle");
    a_ack_next_cycle: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("ack missing one cycle after request");
    a_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    a_unmapped_zero: assert property ((o_wb_ack && !i_wb_we && i_wb_adr == 8'hFC)
        |-> o_wb_dat == 32'h0000_0000) else $error("unmapped read not zero");
    a_cfg_spare_zero: assert property ((o_wb_ack && !i_wb_we &&
        i_wb_adr inside {8'h10, 8'h20, 8'h30, 8'h40}) |-> (o_wb_dat & ~CFG_WR_MASK) == 32'h0000_0000)
        else $error("config spare bits read nonzero");
    a_active_marks_oe: assert property (o_pcm_tx_data_oe ==
        (!o_tx_slot_active_a_n || !o_tx_slot_active_b_n)) else $error("slot active differs from oe");
    a_idle_line_low: assert property (!o_pcm_tx_data_oe |-> !o_pcm_tx_data)
        else $error("tx data driven while released");
    a_launch_on_rise: assert property (($changed(o_pcm_tx_data) ||
        $changed(o_pcm_tx_data_oe)) |-> since_ff inside {[6'h01:6'h0A]})
        else $error("tx change not just after bit clock rise");
    a_slot_length: assert property ($fell(o_pcm_tx_data_oe) |->
        (rises_ff == 5'h08 || rises_ff == 5'h10)) else $error("slot not 8 or 16 bits long");
    a_quiet_release: assert property ($fell(i_reset) |-> (!o_pcm_tx_data_oe &&
        o_tx_slot_active_a_n && o_tx_slot_active_b_n)) else $error("pins active after reset");

    c_companded: cover property ($fell(o_pcm_tx_data_oe) && rises_ff == 5'h08);
    c_linear: cover property ($fell(o_pcm_tx_data_oe) && rises_ff == 5'h10);
    c_read: cover property (o_wb_ack && !i_wb_we);
endmodule

bind pcm_tdm_single_clock_port pcm_tdm_port_checker i_chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pcm_bit_clk(i_pcm_bit_clk),
    .i_frame_sync(i_frame_sync), .i_pcm_rx_data(i_pcm_rx_data), .o_pcm_tx_data(o_pcm_tx_data),
    .o_pcm_tx_data_oe(o_pcm_tx_data_oe), .o_tx_slot_active_a_n(o_tx_slot_active_a_n),
    .o_tx_slot_active_b_n(o_tx_slot_active_b_n)
);

/* pcm_bus_master_model.sv */
`timescale 1ns/1ps
module pcm_bus_master_model (
    input  wire logic        i_rise_mode,
    input  wire logic [31:0] i_rx_frame,
    input  wire logic        i_line,
    output logic             o_bit_clk,
    output logic             o_frame_sync,
    output logic             o_rx_data,
    output logic [31:0]      o_tx_frame,
    output logic             o_frame_done
);
    int   cnt = 0;
    int   pos = -1;
    logic mode_ff = 1'b0;

    initial begin
        o_bit_clk    = 1'b0;
        o_frame_sync = 1'b0;
        o_rx_data    = 1'b0;
        o_tx_frame   = 32'h0000_0000;
        o_frame_done = 1'b0;
    end

    // TDM bus clock runs free; 40 bit periods per frame
    always #80 o_bit_clk = ~o_bit_clk;

    always @(posedge o_bit_clk) begin
        cnt = (cnt == 39) ? 0 : cnt + 1;
        if (cnt == 0) mode_ff = i_rise_mode;
        pos = cnt - 1 - int'(mode_ff);
        #40;
        o_frame_sync = (cnt == 0);
        o_rx_data = (pos >= 0 && pos < 32) ? i_rx_frame[31 - pos] : ~o_rx_data;
    end

    always @(negedge o_bit_clk) begin
        if (pos >= 0 && pos < 32) o_tx_frame[31 - pos] = i_line;
        if (pos == 31) begin
            o_frame_done = 1'b1;
            #20;
            o_frame_done = 1'b0;
        end
    end
endmodule

/* tb_pcm_tdm_single_clock_port.sv */
`timescale 1ns/1ps
`define CHECK(got, want) begin \
    n_compared++; \
    if ((got) !== (want)) begin \
        n_fail++; \
        $display("wrong value at %0t: got %h want %h", $time, got, want); \
    end \
end
module tb_pcm_tdm_single_clock_port;
    import pcm_tdm_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_rdat, tx_frame, rx_frame = 32'h0000_0000, rxp, rx0_e, rx1_e;
    logic        wb_ack, bit_clk, frame_sync, rx_data, tx_data, tx_oe, act_a_n, act_b_n;
    logic        frame_done, line, line_ff = 1'b0, rise_mode = 1'b0, mode;
    logic [2:0]  o0, r0;
    logic [7:0]  d0;
    logic [15:0] d1;
    logic [31:0] exp_rd[$];
    logic [63:0] exp_tx[$];
    logic [31:0] rd_e;
    logic [63:0] tx_e;
    int          n_fail = 0;
    int          n_compared = 0;

    always #2.5 sys_clk = ~sys_clk;

    // Released line toggles so a stale bit can never pass as driven data
    assign line = tx_oe ? tx_data : ~line_ff;
    always @(posedge sys_clk) line_ff <= line;

    pcm_tdm_single_clock_port i_dut (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_wdat),
        .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_pcm_bit_clk(bit_clk),
        .i_frame_sync(frame_sync), .i_pcm_rx_data(rx_data), .o_pcm_tx_data(tx_data),
        .o_pcm_tx_data_oe(tx_oe), .o_tx_slot_active_a_n(act_a_n),
        .o_tx_slot_active_b_n(act_b_n));

    pcm_bus_master_model i_far (
        .i_rise_mode(rise_mode), .i_rx_frame(rx_frame), .i_line(line), .o_bit_clk(bit_clk),
        .o_frame_sync(frame_sync), .o_rx_data(rx_data), .o_tx_frame(tx_frame),
        .o_frame_done(frame_done));

    task automatic close_out();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        // Ack is sampled at the rising edge; release only after it
        @(posedge sys_clk);
        while (wb_ack !== 1'b1) @(posedge sys_clk);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        wb_cycle(1'b0, a, 32'h0000_0000);
    endtask

    always @(posedge sys_clk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_rd.size() > 0) begin
            rd_e = exp_rd.pop_front();
            `CHECK(wb_rdat, rd_e)
        end
    end

    always @(posedge frame_done) begin
        if (exp_tx.size() > 0) begin
            tx_e = exp_tx.pop_front();
            `CHECK(tx_frame & tx_e[63:32], tx_e[31:0])
        end
    end

    initial begin
        #200_000;
        n_fail++;
        close_out();
    end

    initial begin
        void'($urandom(55605));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd_expect(CTRL_OFS, 32'h0000_0000);
        rd_expect(STATUS_OFS, 32'h0000_0000);
        rd_expect(CH_BASE_OFS, CFG_RESET);
        rd_expect(CH_BASE_OFS + CH_TX_DATA_OFS, {16'h0000, TX_DATA_RESET});
        wb_cycle(1'b1, CH_BASE_OFS, 32'hFFFF_FFFF);
        rd_expect(CH_BASE_OFS, CFG_WR_MASK);
        wb_cycle(1'b1, 8'hFC, 32'hFFFF_FFFF);
        rd_expect(8'hFC, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            @(posedge frame_done);
            repeat (20) @(posedge sys_clk);
            if (i > 0) begin
                rd_expect(CH_BASE_OFS + CH_RX_DATA_OFS, rx0_e);
                rd_expect(CH_BASE_OFS + CH_STRIDE + CH_RX_DATA_OFS, rx1_e);
                rd_expect(STATUS_OFS, 32'h0000_0013);
                wb_cycle(1'b1, STATUS_OFS, 32'h0000_0003);
                rd_expect(STATUS_OFS, 32'h0000_0010);
            end
            mode = 1'($urandom_range(1));
            o0 = 3'($urandom_range(7));
            r0 = 3'($urandom_range(7));
            d0 = 8'($urandom);
            d1 = 16'($urandom);
            rxp = $urandom;
            // Channel 0 companded, tx slot 0 and rx slot 2; channel 1 linear, tx slot 2 and rx slot 0; never touching
            wb_cycle(1'b1, CH_BASE_OFS + CH_TX_DATA_OFS, {24'h00_0000, d0});
            wb_cycle(1'b1, CH_BASE_OFS + CH_STRIDE + CH_TX_DATA_OFS, {16'h0000, d1});
            wb_cycle(1'b1, CH_BASE_OFS, 32'h0600_0200 | (32'(o0) << 16) | (32'(r0) << 20));
            wb_cycle(1'b1, CH_BASE_OFS + CH_STRIDE, 32'h0F00_0002);
            wb_cycle(1'b1, CTRL_OFS, {30'h0000_0000, mode, 1'b1});
            rise_mode <= mode;
            rx_frame <= rxp;
            rx0_e = (rxp >> (8 - r0)) & 32'h0000_00FF;
            rx1_e = rxp >> 16;
            exp_tx.push_back({(32'h0000_00FF << (24 - o0)) | 32'h0000_FFFF,
                              (32'(d0) << (24 - o0)) | 32'(d1)});
        end
        @(posedge frame_done);
        repeat (40) @(posedge sys_clk);
        close_out();
    end
endmodule
